// [shared/aux_trigger_io_pin_params.svh]
`ifndef AUX_TRIGGER_IO_PIN_PARAMS_SVH
`define AUX_TRIGGER_IO_PIN_PARAMS_SVH

// Register byte offsets.
`define AUX_OFF_CTRL        8'h00
`define AUX_OFF_PWM_PERIOD  8'h04
`define AUX_OFF_PWM_DUTY    8'h08
`define AUX_OFF_CMD         8'h0C
`define AUX_OFF_STATUS      8'h10

// Control register field positions.
`define AUX_CTRL_FUNC_LSB   0
`define AUX_CTRL_FUNC_MSB   1
`define AUX_CTRL_INVERT     2
`define AUX_CTRL_ACCEPT     3
`define AUX_CTRL_TGT_LSB    4
`define AUX_CTRL_TGT_MSB    5
`define AUX_CTRL_SEQ_EXT    6
`define AUX_CTRL_VAL_LSB    7
`define AUX_CTRL_VAL_MSB    8
`define AUX_CTRL_WIDTH      9

// Command register bit positions.
`define AUX_CMD_ARM_METER   0
`define AUX_CMD_MANUAL_TRIG 1
`define AUX_CMD_INT_TRIG    2

// Status register bit positions.
`define AUX_STAT_LEVEL      0
`define AUX_STAT_ARMED      1
`define AUX_STAT_EMITTING   2
`define AUX_STAT_PIN_RAW    3

// Reset values.
`define AUX_CTRL_RESET      9'h000
`define AUX_PERIOD_RESET    16'h03E8
`define AUX_DUTY_RESET      16'h01F4

// Timing.
`define AUX_CLK_PERIOD_NS   100
`define AUX_PULSE_LOW_NS    30000
`define AUX_PULSE_CYCLES    ((`AUX_PULSE_LOW_NS + `AUX_CLK_PERIOD_NS - 1) / `AUX_CLK_PERIOD_NS)

`endif

// [shared/aux_trigger_io_pkg.sv]
package aux_trigger_io_pkg;

    typedef enum logic [1:0] {
        FUNC_TRIGGER,
        FUNC_INPUT,
        FUNC_OUTPUT
    } pin_func_t;

    typedef enum logic [1:0] {
        VALUE_FALSE,
        VALUE_TRUE,
        VALUE_PWM
    } out_value_t;

    typedef enum logic [1:0] {
        TARGET_METER,
        TARGET_DLOG,
        TARGET_LIST
    } accept_target_t;

    typedef enum logic {
        EMIT_IDLE,
        EMIT_PULSE
    } emit_state_t;

endpackage

// [shared/pwm_if.sv]
`timescale 1ns/1ps
`default_nettype none

interface pwm_if #(
    parameter int WIDTH = 16
);
    logic [WIDTH-1:0] period;
    logic [WIDTH-1:0] duty;
    logic             enable;
    logic             active;

    modport ctrl (output period, output duty, output enable, input active);
    modport gen  (input period, input duty, input enable, output active);
endinterface

`default_nettype wire

// [src/pwm_generator.sv]
`timescale 1ns/1ps
`default_nettype none

module pwm_generator #(
    parameter int WIDTH = 16
) (
    input  wire logic sys_clk,
    input  wire logic rst_n,
    pwm_if.gen        pwm
);
    logic [WIDTH-1:0] count;
    logic [WIDTH-1:0] last;

    // A zero period behaves as a one-cycle period.
    assign last = (pwm.period == '0) ? '0 : pwm.period - 1'b1;

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n || !pwm.enable)
        begin
            count <= '0;
        end
        else if (count >= last)
        begin
            count <= '0;
        end
        else
        begin
            count <= count + 1'b1;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n || !pwm.enable)
        begin
            pwm.active <= 1'b0;
        end
        else
        begin
            pwm.active <= (count < pwm.duty);
        end
    end
endmodule // pwm_generator

`default_nettype wire

// [src/aux_trigger_io_pin.sv]
// Implementation choices: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "aux_trigger_io_pin_params.svh"

module aux_trigger_io_pin
    import aux_trigger_io_pkg::*;
#(
    parameter int PWM_WIDTH    = 16,
    parameter int PULSE_CYCLES = `AUX_PULSE_CYCLES
) (
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output var  logic [31:0] prdata,
    output var  logic        pready,
    output var  logic        pslverr,
    input  wire logic        internal_trigger,
    input  wire logic        pin_in,
    output var  logic        pin_out,
    output var  logic        pin_oe,
    output var  logic        level_in,
    output var  logic        meter_start,
    output var  logic        dlog_start,
    output var  logic        list_start
);
    logic [`AUX_CTRL_WIDTH-1:0] ctrl;
    logic [PWM_WIDTH-1:0]       pwm_period;
    logic [PWM_WIDTH-1:0]       pwm_duty;
    logic                       armed;
    emit_state_t                emit_state;
    logic [15:0]                emit_count;
    logic                       pin_meta;
    logic                       pin_sync;
    logic                       pin_value_q;
    logic                       pin_value;
    logic                       pin_edge;
    logic                       access;
    logic                       wr_en;
    logic                       rd_en;
    logic                       addr_hit;
    logic                       cmd_arm;
    logic                       cmd_manual;
    logic                       cmd_int;
    logic                       emit_req;
    logic                       accept_mode;
    logic                       emit_mode;
    logic                       seq_external;
    logic                       invert;
    pin_func_t                  func;
    out_value_t                 out_value;
    accept_target_t             target;
    logic                       ext_meter;
    logic                       ext_dlog;
    logic                       ext_list;
    logic                       manual_list;
    logic                       next_pin_out;
    logic                       next_pin_oe;
    logic                       drive_value;
    logic [31:0]                next_prdata;
    logic [31:0]                status_word;

    localparam logic [15:0] PULSE_LAST = 16'(PULSE_CYCLES - 1);

    pwm_if #(.WIDTH(PWM_WIDTH)) pwm ();

    pwm_generator #(.WIDTH(PWM_WIDTH)) u_pwm (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .pwm     (pwm.gen)
    );

    // Field decode of the control register.
    assign func         = pin_func_t'(ctrl[`AUX_CTRL_FUNC_MSB:`AUX_CTRL_FUNC_LSB]);
    assign invert       = ctrl[`AUX_CTRL_INVERT];
    assign out_value    = out_value_t'(ctrl[`AUX_CTRL_VAL_MSB:`AUX_CTRL_VAL_LSB]);
    assign target       = accept_target_t'(ctrl[`AUX_CTRL_TGT_MSB:`AUX_CTRL_TGT_LSB]);
    assign seq_external = ctrl[`AUX_CTRL_SEQ_EXT];
    assign accept_mode  = (func == FUNC_TRIGGER) && ctrl[`AUX_CTRL_ACCEPT];
    assign emit_mode    = (func == FUNC_TRIGGER) && !ctrl[`AUX_CTRL_ACCEPT];

    assign pwm.period = pwm_period;
    assign pwm.duty   = pwm_duty;
    assign pwm.enable = (func == FUNC_OUTPUT) && (out_value == VALUE_PWM);

    // APB decode; the access completes on the second access-phase cycle.
    assign access   = psel && penable && pready;
    assign wr_en    = access && pwrite;
    assign rd_en    = psel && penable && !pready && !pwrite;
    assign addr_hit = (paddr == `AUX_OFF_CTRL) || (paddr == `AUX_OFF_PWM_PERIOD) ||
                      (paddr == `AUX_OFF_PWM_DUTY) || (paddr == `AUX_OFF_CMD) ||
                      (paddr == `AUX_OFF_STATUS);

    assign cmd_arm    = wr_en && (paddr == `AUX_OFF_CMD) && pwdata[`AUX_CMD_ARM_METER];
    assign cmd_manual = wr_en && (paddr == `AUX_OFF_CMD) && pwdata[`AUX_CMD_MANUAL_TRIG];
    assign cmd_int    = wr_en && (paddr == `AUX_OFF_CMD) && pwdata[`AUX_CMD_INT_TRIG];

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready  <= psel && penable && !pready;
            pslverr <= psel && penable && !pready && !addr_hit;
        end
    end

    always_comb
    begin
        status_word = 32'h0000_0000;
        status_word[`AUX_STAT_LEVEL]    = pin_value;
        status_word[`AUX_STAT_ARMED]    = armed;
        status_word[`AUX_STAT_EMITTING] = (emit_state == EMIT_PULSE);
        status_word[`AUX_STAT_PIN_RAW]  = pin_sync;
        next_prdata = 32'h0000_0000;
        case (paddr)
            `AUX_OFF_CTRL:       next_prdata = 32'(ctrl);
            `AUX_OFF_PWM_PERIOD: next_prdata = 32'(pwm_period);
            `AUX_OFF_PWM_DUTY:   next_prdata = 32'(pwm_duty);
            `AUX_OFF_STATUS:     next_prdata = status_word;
            default:             next_prdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            prdata <= 32'h0000_0000;
        end
        else if (rd_en)
        begin
            prdata <= next_prdata;
        end
    end

    // Configuration registers.
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            ctrl <= `AUX_CTRL_RESET;
        end
        else if (wr_en && (paddr == `AUX_OFF_CTRL))
        begin
            ctrl <= pwdata[`AUX_CTRL_WIDTH-1:0];
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            pwm_period <= PWM_WIDTH'(`AUX_PERIOD_RESET);
            pwm_duty   <= PWM_WIDTH'(`AUX_DUTY_RESET);
        end
        else if (wr_en && (paddr == `AUX_OFF_PWM_PERIOD))
        begin
            pwm_period <= pwdata[PWM_WIDTH-1:0];
        end
        else if (wr_en && (paddr == `AUX_OFF_PWM_DUTY))
        begin
            pwm_duty <= pwdata[PWM_WIDTH-1:0];
        end
    end

    // Pin synchroniser and polarity; the logical value is true on the active level.
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            pin_meta <= 1'b1;
            pin_sync <= 1'b1;
        end
        else
        begin
            pin_meta <= pin_in;
            pin_sync <= pin_meta;
        end
    end

    assign pin_value = pin_sync ^ !invert;

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            pin_value_q <= 1'b0;
            level_in    <= 1'b0;
        end
        else
        begin
            pin_value_q <= pin_value;
            level_in    <= (func == FUNC_INPUT) ? pin_value : 1'b0;
        end
    end

    // Start of an external pulse's active phase; the source holds it long enough.
    assign pin_edge    = accept_mode && pin_value && !pin_value_q;
    assign ext_meter   = pin_edge && (target == TARGET_METER) && armed;
    assign ext_dlog    = pin_edge && (target == TARGET_DLOG);
    assign ext_list    = pin_edge && (target == TARGET_LIST) && seq_external;
    assign manual_list = cmd_manual && !seq_external;

    // Meter arming; a new arm in the same cycle as a start wins.
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            armed <= 1'b0;
        end
        else if (cmd_arm)
        begin
            armed <= 1'b1;
        end
        else if (ext_meter)
        begin
            armed <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            meter_start <= 1'b0;
            dlog_start  <= 1'b0;
            list_start  <= 1'b0;
        end
        else
        begin
            meter_start <= ext_meter;
            dlog_start  <= ext_dlog;
            list_start  <= ext_list || manual_list;
        end
    end

    // Emitted trigger pulse; a new trigger during a pulse restarts its width.
    assign emit_req = emit_mode && (internal_trigger || cmd_int || cmd_manual);

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            emit_state <= EMIT_IDLE;
            emit_count <= 16'h0000;
        end
        else
        begin
            case (emit_state)
                EMIT_IDLE:
                begin
                    if (emit_req)
                    begin
                        emit_state <= EMIT_PULSE;
                        emit_count <= 16'h0000;
                    end
                end
                EMIT_PULSE:
                begin
                    if (emit_req)
                    begin
                        emit_count <= 16'h0000;
                    end
                    else if (!emit_mode || (emit_count >= PULSE_LAST))
                    begin
                        emit_state <= EMIT_IDLE;
                    end
                    else
                    begin
                        emit_count <= emit_count + 16'h0001;
                    end
                end
                default:
                begin
                    emit_state <= EMIT_IDLE;
                    emit_count <= 16'h0000;
                end
            endcase
        end
    end

    // Pin driver; the logical value maps to a low level unless polarity is flipped.
    always_comb
    begin
        drive_value  = 1'b0;
        next_pin_oe  = 1'b0;
        next_pin_out = 1'b0;
        case (func)
            FUNC_TRIGGER:
            begin
                drive_value = (emit_state == EMIT_PULSE);
                next_pin_oe = emit_mode;
            end
            FUNC_INPUT:
            begin
                drive_value = 1'b0;
                next_pin_oe = 1'b0;
            end
            FUNC_OUTPUT:
            begin
                next_pin_oe = 1'b1;
                case (out_value)
                    VALUE_TRUE:  drive_value = 1'b1;
                    VALUE_FALSE: drive_value = 1'b0;
                    VALUE_PWM:   drive_value = pwm.active;
                    default:     drive_value = 1'b0;
                endcase
            end
            default:
            begin
                drive_value = 1'b0;
                next_pin_oe = 1'b0;
            end
        endcase
        next_pin_out = invert ? drive_value : !drive_value;
        if (!next_pin_oe)
        begin
            next_pin_out = 1'b0;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            pin_out <= 1'b0;
            pin_oe  <= 1'b0;
        end
        else
        begin
            pin_out <= next_pin_out;
            pin_oe  <= next_pin_oe;
        end
    end
endmodule // aux_trigger_io_pin

`default_nettype wire

// [sim/ext_equipment.sv]
`timescale 1ns/1ps
`default_nettype none

module ext_equipment #(
    parameter int HOLD = 300
) (
    input  wire logic sys_clk,
    input  wire logic pin_out,
    input  wire logic pin_oe,
    input  wire logic pulse_req,
    output var  logic pin_in,
    output var  logic busy
);
    int low_left = 0;

    // Each pulse holds the pin low for the full minimum width.
    always @(posedge sys_clk)
    begin
        if (pulse_req && low_left == 0)
            low_left <= HOLD;
        else if (low_left > 0)
            low_left <= low_left - 1;
    end

    // The pin rests at its pull-up level when nobody drives it.
    always_comb
    begin
        busy = (low_left > 0);
        pin_in = busy ? 1'b0 : (pin_oe ? pin_out : 1'b1);
    end
endmodule // ext_equipment

`default_nettype wire

// [sim/aux_trigger_io_pin_asserts.sv]
`timescale 1ns/1ps
`default_nettype none

module aux_trigger_io_pin_asserts (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic pin_out,
    input wire logic pin_oe,
    input wire logic level_in,
    input wire logic meter_start,
    input wire logic dlog_start,
    input wire logic list_start
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    sequence access_start;
        psel && $rose(penable);
    endsequence

    chk_ready_latency: assert property (access_start |=> pready)
        else $error("pready missing one cycle into access");
    chk_ready_single: assert property (pready |=> !pready)
        else $error("pready held too long");
    chk_ready_access: assert property (pready |-> psel && penable)
        else $error("pready outside access phase");
    chk_error_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    chk_released_low: assert property (!pin_oe |-> !pin_out)
        else $error("pin_out high while released");
    chk_one_target: assert property ($onehot0({meter_start, dlog_start, list_start}))
        else $error("more than one target started");
    chk_accept_start: assert property ((meter_start || dlog_start) |-> !pin_oe
        ##1 !(meter_start || dlog_start))
        else $error("start while driving or too long");
    chk_list_single: assert property (list_start |=> !list_start)
        else $error("list start longer than one cycle");
    chk_level_undriven: assert property (level_in |-> !pin_oe)
        else $error("level_in set while pin driven");
endmodule // aux_trigger_io_pin_asserts

`default_nettype wire

// [sim/aux_trigger_io_pin_bench.sv]
`timescale 1ns/1ps
`default_nettype none

module aux_trigger_io_pin_bench;
    localparam int PC = 5;
    typedef struct {logic [8:0] ctrl; logic oe; logic out; logic lvl;} row_t;
    typedef struct {logic [8:0] ctrl; logic arm; int tgt;} acc_t;
    logic        sys_clk, rst_n, psel, penable, pwrite, internal_trigger, pulse_req;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        pready, pslverr, pin_in, pin_out, pin_oe, level_in, er, busy;
    logic        meter_start, dlog_start, list_start;
    int          errors = 0;
    int          check_count = 0;
    int          starts [3] = '{0, 0, 0};
    int          base [3];
    int          n;
    row_t rows [8] = '{'{9'h000, 1, 1, 0}, '{9'h004, 1, 0, 0}, '{9'h082, 1, 0, 0},
        '{9'h086, 1, 1, 0}, '{9'h002, 1, 1, 0}, '{9'h006, 1, 0, 0},
        '{9'h001, 0, 0, 0}, '{9'h005, 0, 0, 1}};
    acc_t accs [5] = '{'{9'h068, 0, 2}, '{9'h028, 0, 3}, '{9'h008, 0, 3},
        '{9'h008, 1, 0}, '{9'h018, 0, 1}};

    aux_trigger_io_pin #(.PULSE_CYCLES(PC)) DUT (.sys_clk(sys_clk), .rst_n(rst_n),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .internal_trigger(internal_trigger), .pin_in(pin_in), .pin_out(pin_out),
        .pin_oe(pin_oe), .level_in(level_in), .meter_start(meter_start),
        .dlog_start(dlog_start), .list_start(list_start));

    ext_equipment #(.HOLD(300)) far (.sys_clk(sys_clk), .pin_out(pin_out),
        .pin_oe(pin_oe), .pulse_req(pulse_req), .pin_in(pin_in), .busy(busy));

    initial
    begin
        sys_clk = 0;
        forever #50 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk)
    begin
        if (meter_start === 1'b1) starts[0]++;
        if (dlog_start === 1'b1) starts[1]++;
        if (list_start === 1'b1) starts[2]++;
    end

    task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            errors++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task conclude;
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do
        begin
            @(posedge sys_clk);
        end
        while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask

    task pulse_pin;
        pulse_req <= 1'b1;
        @(posedge sys_clk);
        pulse_req <= 1'b0;
        @(posedge sys_clk);
    endtask

    task measure_low;
        int w;
        w = 0;
        n = 0;
        #1;
        while (pin_out !== 1'b0 && w < 20)
        begin
            @(posedge sys_clk);
            #1 w++;
        end
        while (pin_out === 1'b0 && n < 2000)
        begin
            @(posedge sys_clk);
            #1 n++;
        end
    endtask

    initial
    begin
        rst_n = 0; psel = 0; penable = 0; pwrite = 0; paddr = 8'h00;
        pwdata = 32'h0; internal_trigger = 0; pulse_req = 0;
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        #1 check("reset_oe", pin_oe, 1'b1);
        check("reset_out", pin_out, 1'b1);
        @(posedge sys_clk);
        apb(0, 8'h00, 0);
        check("ctrl", rd, 32'h0);
        apb(0, 8'h04, 0);
        check("period", rd, 32'h3E8);
        apb(0, 8'h08, 0);
        check("duty", rd, 32'h1F4);
        apb(0, 8'h20, 0);
        check("unmapped", {er, rd[30:0]}, 32'h80000000);
        foreach (rows[i])
        begin
            apb(1, 8'h00, {23'h0, rows[i].ctrl});
            repeat (4) @(posedge sys_clk);
            #1 check("oe", pin_oe, rows[i].oe);
            check("out", pin_out, rows[i].out);
            check("level", level_in, rows[i].lvl);
        end
        apb(1, 8'h00, 32'h1);
        pulse_pin();
        repeat (8) @(posedge sys_clk);
        #1 check("level_low", level_in, 1'b1);
        while (busy) @(posedge sys_clk);
        apb(1, 8'h00, 32'h0);
        internal_trigger <= 1'b1;
        @(posedge sys_clk);
        internal_trigger <= 1'b0;
        measure_low();
        check("emit_width", n, PC);
        base = starts;
        apb(1, 8'h0C, 32'h2);
        measure_low();
        check("manual_width", n, PC);
        check("manual_list", starts[2], base[2] + 1);
        foreach (accs[i])
        begin
            apb(1, 8'h00, {23'h0, accs[i].ctrl});
            if (accs[i].arm) apb(1, 8'h0C, 32'h1);
            base = starts;
            pulse_pin();
            while (busy) @(posedge sys_clk);
            repeat (10) @(posedge sys_clk);
            for (int t = 0; t < 3; t++)
                check("starts", starts[t], base[t] + (t == accs[i].tgt));
        end
        apb(1, 8'h04, 32'h4);
        apb(1, 8'h08, 32'h1);
        apb(1, 8'h00, 32'h102);
        repeat (10) @(posedge sys_clk);
        n = 0;
        repeat (40)
        begin
            @(posedge sys_clk);
            #1 if (pin_out === 1'b0) n++;
        end
        check("pwm_active", n, 10);
        @(posedge sys_clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        #1 check("rerun_pin", {pin_oe, pin_out}, 2'b11);
        @(posedge sys_clk);
        apb(0, 8'h04, 0);
        check("rerun_period", rd, 32'h3E8);
        apb(0, 8'h10, 0);
        check("status", rd, 32'h8);
        conclude();
    end

    initial
    begin
        repeat (20000) @(posedge sys_clk);
        errors++;
        conclude();
    end
endmodule // aux_trigger_io_pin_bench

bind aux_trigger_io_pin aux_trigger_io_pin_asserts u_asserts (.sys_clk(sys_clk),
    .rst_n(rst_n), .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
    .pin_out(pin_out), .pin_oe(pin_oe), .level_in(level_in), .meter_start(meter_start),
    .dlog_start(dlog_start), .list_start(list_start));

`default_nettype wire
